/* File: include/ricr_pkg.sv */
package ricr_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_REF = 4;
  localparam int NUM_PROF = 8;
  // register offsets
  localparam logic [11:0] OFF_POWER_DOWN = 12'h0500;
  localparam logic [11:0] OFF_FAMILY = 12'h0501;
  localparam logic [11:0] OFF_UNUSED_0 = 12'h0502;
  localparam logic [11:0] OFF_PROFILE_FIRST = 12'h0503;
  localparam logic [11:0] OFF_PROFILE_SECOND = 12'h0504;
  localparam logic [11:0] OFF_UNUSED_1 = 12'h0505;
  localparam logic [11:0] OFF_UNUSED_2 = 12'h0506;
  localparam logic [11:0] OFF_THRESHOLD = 12'h0507;
  // reset values
  localparam logic [7:0] RST_POWER_DOWN = 8'h00;
  localparam logic [7:0] RST_FAMILY = 8'h00;
  localparam logic [7:0] RST_PROFILE = 8'h00;
  localparam logic [2:0] RST_THRESHOLD = 3'h0;
  localparam logic [2:0] RST_PRIORITY = 3'h0;
  // power-down layout: bit index per receiver, upper bits unused
  localparam int PD_FIRST = 0;
  localparam int PD_FIRST_PARTNER = 1;
  localparam int PD_SECOND = 2;
  localparam int PD_SECOND_PARTNER = 3;
  localparam logic [7:0] PD_ALL = 8'hFF;
  // family field positions (low bit of each two-bit field)
  localparam int FAM_FIRST_LSB = 0;
  localparam int FAM_FIRST_PARTNER_LSB = 2;
  localparam int FAM_SECOND_LSB = 4;
  localparam int FAM_SECOND_PARTNER_LSB = 6;
  // profile select field positions
  localparam int PSEL_PRIMARY_LSB = 0;
  localparam int PSEL_PRIMARY_MAN = 3;
  localparam int PSEL_PARTNER_LSB = 4;
  localparam int PSEL_PARTNER_MAN = 7;
  localparam int THRESH_W = 3;
  localparam int PROF_W = 3;
  localparam int PRIO_W = 3;

  typedef enum logic [1:0] {
    RICR_FAM_DIFF_OR_OFF,
    RICR_FAM_CMOS_LOW,
    RICR_FAM_CMOS_MID,
    RICR_FAM_CMOS_HIGH
  } ricr_family_t;

  typedef enum logic [2:0] {
    RICR_RX_OFF,
    RICR_RX_DIFF,
    RICR_RX_CMOS_LOW,
    RICR_RX_CMOS_MID,
    RICR_RX_CMOS_HIGH
  } ricr_rx_mode_t;
endpackage

/* File: rtl/ricr_regs.sv */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// Function
// R1 - one power-down bit per receiver (first 0, partner 1, second 2, partner 3), 1 powers down, reset 0.
// R2 - when every power-down bit is set the whole receiver section goes into deep sleep.
// R3 - software writes ones to the four unused upper power-down bits on every write.
// R4 - second primary family 00 pairs the pins differentially, 01..11 pick low, mid, high CMOS.
// R5 - second partner family 00 disables it, 01..11 pick CMOS, ignored while its primary is differential.
// R6 - the first pair uses the same encodings at bits 3:2 (partner) and 1:0 (primary).
// R7 - each receiver has a mode bit, 0 automatic and 1 manual profile assignment, reset 0.
// R8 - manual profile is a 3-bit number 0..7, reset 0, applied only in manual mode.
// R9 - first pair profile select: partner at bits 7 and 6:4, primary at bits 3 and 2:0.
// R10 - second pair profile select: partner at bits 7 and 6:4, primary at bits 3 and 2:0.
// R11 - a 3-bit threshold, reset 0; a reference with selection priority below it is a phase main.
// R12 - selection priority is a 3-bit field of the profile tied to each reference.
// R13 - all eight profile register sets reset to zero; this module holds none, priorities come in on PROF_PRIORITY with no reset.
// R14 - a powered-down or disabled receiver passes no reference edges downstream.
module ricr_regs
  import ricr_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // raw receiver inputs: first, first partner, second, second partner
  input wire logic [NUM_REF-1:0] REF_IN,
  // profile selection priorities, profile p at bits [3p+2:3p]
  input wire logic [NUM_PROF*PRIO_W-1:0] PROF_PRIORITY,
  // automatic profile choice from the switchover logic
  input wire logic [NUM_REF*PROF_W-1:0] AUTO_PROFILE,
  // outputs to analog front end and downstream logic
  output logic [NUM_REF-1:0] REF_OUT,
  output logic [NUM_REF-1:0] RX_ENABLE,
  output logic [NUM_REF*3-1:0] RX_MODE,
  output logic DEEP_SLEEP,
  output logic [NUM_REF*PROF_W-1:0] REF_PROFILE,
  output logic [NUM_REF-1:0] REF_MANUAL,
  output logic [NUM_REF-1:0] PHASE_MAIN
);

  logic [7:0] power_down;
  logic [7:0] family;
  logic [7:0] prof_first;
  logic [7:0] prof_second;
  logic [THRESH_W-1:0] threshold;
  logic [NUM_REF*3-1:0] next_rx_mode;
  logic [NUM_REF-1:0] next_enable;
  logic [NUM_REF*PROF_W-1:0] next_profile;
  logic [NUM_REF-1:0] next_manual;
  logic [NUM_REF-1:0] next_main;
  logic next_sleep;

  // decode a two-bit family field; primary 00 means differential
  function automatic ricr_rx_mode_t fam_decode(input logic [1:0] f,
                                               input logic primary);
    ricr_rx_mode_t m;
    unique case (ricr_family_t'(f))
      RICR_FAM_DIFF_OR_OFF: m = primary ? RICR_RX_DIFF : RICR_RX_OFF;
      RICR_FAM_CMOS_LOW: m = RICR_RX_CMOS_LOW;
      RICR_FAM_CMOS_MID: m = RICR_RX_CMOS_MID;
      RICR_FAM_CMOS_HIGH: m = RICR_RX_CMOS_HIGH;
    endcase
    return m;
  endfunction

  // software-written registers
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      power_down <= RST_POWER_DOWN; // R1
      family <= RST_FAMILY;
      prof_first <= RST_PROFILE; // R7 R8
      prof_second <= RST_PROFILE;
      threshold <= RST_THRESHOLD; // R11
    end
    else if (WR)
    begin
      unique case (ADDR)
        // upper bits kept as written; software is expected to set them
        OFF_POWER_DOWN: power_down <= WDATA; // R1 R3
        OFF_FAMILY: family <= WDATA; // R4 R5 R6
        OFF_PROFILE_FIRST: prof_first <= WDATA; // R9
        OFF_PROFILE_SECOND: prof_second <= WDATA; // R10
        OFF_THRESHOLD: threshold <= WDATA[THRESH_W-1:0]; // R11
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
      RDATA <= '0;
    else if (RD)
    begin
      unique case (ADDR)
        OFF_POWER_DOWN: RDATA <= power_down;
        OFF_FAMILY: RDATA <= family;
        OFF_PROFILE_FIRST: RDATA <= prof_first;
        OFF_PROFILE_SECOND: RDATA <= prof_second;
        OFF_THRESHOLD: RDATA <= {{(DATA_W-THRESH_W){1'b0}}, threshold};
        default: RDATA <= '0;
      endcase
    end
    else
      RDATA <= '0;
  end

  // per-receiver decode
  always_comb
  begin
    logic [2:0] pidx;
    logic [PROF_W-1:0] auto_p;
    logic [PRIO_W-1:0] prio;
    ricr_rx_mode_t m [NUM_REF];
    logic [NUM_REF-1:0] man;
    logic [PROF_W-1:0] mp [NUM_REF];
    pidx = '0;
    auto_p = '0;
    prio = '0;
    m[0] = fam_decode(family[FAM_FIRST_LSB+:2], 1'b1); // R6
    m[1] = fam_decode(family[FAM_FIRST_PARTNER_LSB+:2], 1'b0); // R6
    m[2] = fam_decode(family[FAM_SECOND_LSB+:2], 1'b1); // R4
    m[3] = fam_decode(family[FAM_SECOND_PARTNER_LSB+:2], 1'b0); // R5
    // partner is ignored while its primary runs differential
    if (m[0] == RICR_RX_DIFF)
      m[1] = RICR_RX_OFF; // R5 R6
    if (m[2] == RICR_RX_DIFF)
      m[3] = RICR_RX_OFF; // R5
    man[0] = prof_first[PSEL_PRIMARY_MAN]; // R9
    man[1] = prof_first[PSEL_PARTNER_MAN];
    man[2] = prof_second[PSEL_PRIMARY_MAN]; // R10
    man[3] = prof_second[PSEL_PARTNER_MAN];
    mp[0] = prof_first[PSEL_PRIMARY_LSB+:PROF_W];
    mp[1] = prof_first[PSEL_PARTNER_LSB+:PROF_W];
    mp[2] = prof_second[PSEL_PRIMARY_LSB+:PROF_W];
    mp[3] = prof_second[PSEL_PARTNER_LSB+:PROF_W];
    next_sleep = (power_down == PD_ALL); // R2
    for (int i = 0; i < NUM_REF; i++)
    begin
      next_rx_mode[i*3+:3] = m[i];
      next_enable[i] = !power_down[i] && !next_sleep &&
                       (m[i] != RICR_RX_OFF); // R1 R14
      auto_p = AUTO_PROFILE[i*PROF_W+:PROF_W];
      pidx = man[i] ? mp[i] : auto_p; // R7 R8
      next_profile[i*PROF_W+:PROF_W] = pidx;
      next_manual[i] = man[i];
      prio = PROF_PRIORITY[pidx*PRIO_W+:PRIO_W]; // R12 R13
      next_main[i] = (prio < threshold); // R11
    end
  end

  // registered configuration outputs
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RX_MODE <= '0;
      RX_ENABLE <= '0;
      DEEP_SLEEP <= 1'b0;
      REF_PROFILE <= '0;
      REF_MANUAL <= '0;
      PHASE_MAIN <= '0;
    end
    else
    begin
      RX_MODE <= next_rx_mode;
      RX_ENABLE <= next_enable;
      DEEP_SLEEP <= next_sleep; // R2
      REF_PROFILE <= next_profile;
      REF_MANUAL <= next_manual;
      PHASE_MAIN <= next_main; // R11
    end
  end

  // gated reference samples; disabled receivers hold low
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
      REF_OUT <= '0;
    else
      REF_OUT <= REF_IN & next_enable; // R14
  end

endmodule // ricr_regs

/* File: dv/ricr_regs_monitor.sv */
`timescale 1ns/1ps
module ricr_regs_monitor
  import ricr_pkg::*;
(
  // bus
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [DATA_W-1:0] RDATA,
  // receivers
  input wire logic [NUM_REF-1:0] REF_IN,
  input wire logic [NUM_REF-1:0] REF_OUT,
  input wire logic [NUM_REF-1:0] RX_ENABLE,
  input wire logic [NUM_REF*3-1:0] RX_MODE,
  input wire logic DEEP_SLEEP
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_sleep_off; DEEP_SLEEP |-> RX_ENABLE == 4'h0; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("awake rx");
  // sleep only moves two edges after a power-down write
  property p_sleep_cause;
    $changed(DEEP_SLEEP) |-> $past(WR, 2) && $past(ADDR, 2) == OFF_POWER_DOWN;
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep");
  property p_gate;
    !$past(SYS_RST, 2) |-> REF_OUT == ($past(REF_IN) & RX_ENABLE);
  endproperty
  a_gate: assert property (p_gate) else $error("edge leak");
  property p_b_pair; RX_MODE[8:6] == 3'h1 |-> RX_MODE[11:9] == 3'h0; endproperty
  a_b_pair: assert property (p_b_pair) else $error("b partner");
  property p_a_pair; RX_MODE[2:0] == 3'h1 |-> RX_MODE[5:3] == 3'h0; endproperty
  a_a_pair: assert property (p_a_pair) else $error("a partner");
  property p_no_diff; RX_MODE[5:3] != 3'h1 && RX_MODE[11:9] != 3'h1; endproperty
  a_no_diff: assert property (p_no_diff) else $error("partner diff");
  property p_part_en; RX_ENABLE[3] |-> RX_MODE[11:9] != 3'h0; endproperty
  a_part_en: assert property (p_part_en) else $error("off rx on");
endmodule // ricr_regs_monitor
bind ricr_regs ricr_regs_monitor ricr_regs_monitor_i (.*);

/* File: dv/tb_ricr_regs.sv */
`timescale 1ns/1ps
module tb_ricr_regs
  import ricr_pkg::*;
  ;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [ADDR_W-1:0] ADDR = '0;
  logic [DATA_W-1:0] WDATA = '0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [NUM_REF-1:0] REF_IN = '0;
  logic [NUM_PROF*PRIO_W-1:0] PROF_PRIORITY = 24'hFA_C688;
  logic [NUM_REF*PROF_W-1:0] AUTO_PROFILE = 12'h050E;
  logic [DATA_W-1:0] RDATA;
  logic [NUM_REF-1:0] REF_OUT, RX_ENABLE, REF_MANUAL, PHASE_MAIN;
  logic [NUM_REF*3-1:0] RX_MODE;
  logic [NUM_REF*PROF_W-1:0] REF_PROFILE;
  logic DEEP_SLEEP;
  logic [7:0] fams [5] = '{8'h55, 8'hAA, 8'hC0, 8'h0C, 8'hFF};
  logic [7:0] pds [3] = '{8'hF2, 8'hFF, 8'hF0};
  int n_mismatch = 0;
  int n_compared = 0;
  ricr_regs ricr_regs_i (.*);
  initial
    forever #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK)
    REF_IN <= REF_IN + 4'h1;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge CLOCK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 chk(16'(RDATA), 16'(e));
  endtask
  // derived outputs lag the register by one more edge
  task automatic settle;
    repeat (2) @(posedge CLOCK);
    #1;
  endtask
  // enables and modes expected from a family byte
  function automatic logic [15:0] modes(input logic [7:0] f);
    logic [11:0] r;
    logic [1:0] p;
    logic [1:0] q;
    for (int i = 0; i < 4; i += 2)
    begin
      p = f[2*i+:2];
      q = f[2*i+2+:2];
      r[3*i+:3] = (p == 2'h0) ? 3'h1 : {1'b0, p} + 3'h1;
      r[3*i+3+:3] = (p == 2'h0 || q == 2'h0) ? 3'h0 : {1'b0, q} + 3'h1;
    end
    return {|r[11:9], |r[8:6], |r[5:3], |r[2:0], r};
  endfunction
  task automatic end_of_test;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    for (int a = 0; a < 8; a++)
      rd(OFF_POWER_DOWN + 12'(a), 8'h00);
    settle();
    chk({RX_ENABLE, RX_MODE}, modes(8'h00));
    foreach (fams[k])
    begin
      wr(OFF_FAMILY, fams[k]);
      settle();
      chk({RX_ENABLE, RX_MODE}, modes(fams[k]));
    end
    rd(OFF_FAMILY, 8'hFF);
    foreach (pds[k])
    begin
      wr(OFF_POWER_DOWN, pds[k]);
      settle();
      chk({DEEP_SLEEP, RX_ENABLE}, {pds[k] == 8'hFF, pds[k] == 8'hFF ?
        4'h0 : ~pds[k][3:0]});
    end
    rd(OFF_POWER_DOWN, 8'hF0);
    wr(OFF_PROFILE_FIRST, 8'hB5);
    wr(OFF_PROFILE_SECOND, 8'h7F);
    wr(OFF_THRESHOLD, 8'hFC);
    settle();
    chk({REF_MANUAL, REF_PROFILE}, {4'h6, 12'h5DE});
    rd(OFF_THRESHOLD, 8'h04);
    rd(OFF_PROFILE_SECOND, 8'h7F);
    for (int t = 0; t < 8; t++)
    begin
      wr(OFF_THRESHOLD, 8'(t));
      settle();
      chk(16'(PHASE_MAIN), {12'h000, t > 2, t > 7, t > 3, t > 6});
    end
    wr(OFF_UNUSED_0, 8'hFF);
    rd(OFF_UNUSED_0, 8'h00);
    wr(12'h508, 8'hFF);
    rd(12'h508, 8'h00);
    SYS_RST <= 1'b1;
    @(posedge CLOCK);
    SYS_RST <= 1'b0;
    rd(OFF_POWER_DOWN, 8'h00);
    chk({REF_MANUAL, REF_PROFILE}, {4'h0, 12'h050E});
    end_of_test();
  end
endmodule // tb_ricr_regs
